//--- hw/eclk_ctrl.sv
// Design: command, status and password-lock logic of the EEPROM controller
`timescale 1ns/1ps
module eclk_ctrl #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Array fabric
  output logic fab_start_out,
  output eclk_pkg::eclk_req_t fab_req_out,
  input wire logic fab_done_in,
  input wire logic [31:0] boot_word_in,
  input wire logic boot_valid_in,
  // Interrupt
  output logic irq_out
);

  // Register offsets need at least eight address bits
  if (ADDR_W < 8) begin : g_addr_check
    $error("ADDR_W too small");
  end

  // ==========================================================
  // Decode
  logic wr_launch, wr_status, wr_mask, wr_key, wr_cmp;
  logic [2:0] cmd_new;
  logic cmd_legal;
  logic launch_err;
  logic launch_go;
  eclk_pkg::eclk_state_t state;
  logic busy, done_flag, err_flag, lock_bit, key_written;
  logic [1:0] mask;
  logic [30:0] key;
  logic [31:0] launch_reg;

  assign wr_launch = reg_wr_in && reg_addr_in[7:0] == eclk_pkg::OFS_LAUNCH;
  assign wr_status = reg_wr_in && reg_addr_in[7:0] == eclk_pkg::OFS_STATUS;
  assign wr_mask = reg_wr_in && reg_addr_in[7:0] == eclk_pkg::OFS_MASK;
  assign wr_key = reg_wr_in && reg_addr_in[7:0] == eclk_pkg::OFS_KEY;
  assign wr_cmp = reg_wr_in && reg_addr_in[7:0] == eclk_pkg::OFS_CMP;
  assign cmd_new = reg_wdata_in[eclk_pkg::CMD_LSB +: 3];
  assign cmd_legal = cmd_new[2] == 1'b0;
  // Busy, undefined code or lock make the launch an error
  assign launch_err = wr_launch && (busy || !cmd_legal || lock_bit);
  assign launch_go = wr_launch && !launch_err;
  assign busy = state != eclk_pkg::ECLK_ST_IDLE;

  // ==========================================================
  // Execute register
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      launch_reg <= eclk_pkg::LAUNCH_RST;
    end else if (launch_go) begin
      launch_reg <= reg_wdata_in;
    end
  end

  // ==========================================================
  // Transfer sequencer
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= eclk_pkg::ECLK_ST_BOOT;
    end else begin
      unique case (state)
        eclk_pkg::ECLK_ST_BOOT: begin
          if (boot_valid_in) begin
            state <= eclk_pkg::ECLK_ST_IDLE;
          end
        end
        eclk_pkg::ECLK_ST_IDLE: begin
          if (launch_go) begin
            state <= eclk_pkg::ECLK_ST_RUN;
          end
        end
        eclk_pkg::ECLK_ST_RUN: begin
          if (fab_done_in) begin
            state <= eclk_pkg::ECLK_ST_IDLE;
          end
        end
        default: state <= eclk_pkg::ECLK_ST_IDLE;
      endcase
    end
  end

  // Start is a one-cycle pulse; a refused launch never raises it
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fab_start_out <= 1'b0;
    end else begin
      fab_start_out <= launch_go;
    end
  end

  // Request data registered and held until the next accepted launch
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fab_req_out <= '0;
    end else begin
      if (launch_go) begin
        fab_req_out.cmd <= cmd_new;
        if (cmd_new[1]) begin
          // Status commands use buffer byte 0 only
          fab_req_out.addr <= '0;
          fab_req_out.count <= 6'h01;
        end else begin
          fab_req_out.addr <= reg_wdata_in[10:0];
          if (reg_wdata_in[eclk_pkg::SIZE_LSB +: 5] == 5'h00) begin
            fab_req_out.count <= eclk_pkg::FULL_COUNT;
          end else begin
            fab_req_out.count <= {1'b0,
              reg_wdata_in[eclk_pkg::SIZE_LSB +: 5]};
          end
        end
      end
    end
  end

  // ==========================================================
  // Status flags; a set in the same cycle as a clear wins
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_flag <= 1'b0;
    end else if (state == eclk_pkg::ECLK_ST_RUN && fab_done_in) begin
      done_flag <= 1'b1;
    end else if (wr_status && reg_wdata_in[eclk_pkg::DONE_BIT]) begin
      done_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      err_flag <= 1'b0;
    end else if (launch_err) begin
      err_flag <= 1'b1;
    end else if (wr_status && reg_wdata_in[eclk_pkg::ERR_BIT]) begin
      err_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mask <= eclk_pkg::MASK_RST;
    end else if (wr_mask) begin
      mask <= reg_wdata_in[1:0];
    end
  end

  assign irq_out = (mask[1] && err_flag) || (mask[0] && done_flag);

  // ==========================================================
  // Key and lock
  // Key is write-once for firmware; the boot word may preload it
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      key <= eclk_pkg::KEY_RST;
      key_written <= 1'b0;
    end else if (state == eclk_pkg::ECLK_ST_BOOT) begin
      if (boot_valid_in && boot_word_in[eclk_pkg::KEY_VALID_BIT]) begin
        key <= boot_word_in[30:0];
      end
    end else if (wr_key && !key_written) begin
      key <= reg_wdata_in[30:0];
      key_written <= 1'b1;
    end
  end

  // Lock leaves only by reset or a matching compare write
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lock_bit <= 1'b0;
    end else if (state == eclk_pkg::ECLK_ST_BOOT) begin
      if (boot_valid_in && boot_word_in[eclk_pkg::KEY_VALID_BIT]) begin
        lock_bit <= 1'b1;
      end
    end else if (wr_cmp && reg_wdata_in[30:0] == key) begin
      lock_bit <= 1'b0;
    end
  end

  // ==========================================================
  // Read port; key and compare registers read as zero
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in[7:0])
        eclk_pkg::OFS_LAUNCH: reg_rdata_out <= {3'h0, launch_reg[28:24],
          5'h00, launch_reg[18:0]};
        eclk_pkg::OFS_STATUS: reg_rdata_out <= {23'h0, busy, 6'h00,
          err_flag, done_flag};
        eclk_pkg::OFS_MASK: reg_rdata_out <= {30'h0, mask};
        eclk_pkg::OFS_LOCK: reg_rdata_out <= {30'h0, lock_bit, 1'b0};
        default: reg_rdata_out <= '0;
      endcase
    end else begin
      reg_rdata_out <= '0;
    end
  end

  // ==========================================================
  // Checks
  // Busy also falls when boot ends; only a transfer end must set done
  a_busy_done_edge: assert property (@(posedge clock_in) disable iff
    (!resetn_in) $fell(busy) && $past(state) == eclk_pkg::ECLK_ST_RUN
    |-> done_flag)
    else $error("busy fell without done");
  a_launch_sets_busy: assert property (@(posedge clock_in) disable iff
    (!resetn_in) launch_go |=> busy && fab_start_out)
    else $error("launch did not start");
  a_busy_write_err: assert property (@(posedge clock_in) disable iff
    (!resetn_in) (wr_launch && busy) |=> err_flag)
    else $error("busy launch no error");
  a_bad_cmd_err: assert property (@(posedge clock_in) disable iff
    (!resetn_in) (wr_launch && reg_wdata_in[18]) |=> err_flag && !$rose(busy))
    else $error("bad command no error");
  a_err_no_start: assert property (@(posedge clock_in) disable iff
    (!resetn_in) launch_err |=> !fab_start_out)
    else $error("error launch started");
  a_irq_err: assert property (@(posedge clock_in) disable iff
    (!resetn_in) (mask[1] && err_flag) |-> irq_out)
    else $error("error irq missing");
  a_irq_done: assert property (@(posedge clock_in) disable iff
    (!resetn_in) irq_out |-> (mask[0] && done_flag) || (mask[1] && err_flag))
    else $error("spurious irq");
  a_cmp_read_zero: assert property (@(posedge clock_in) disable iff
    (!resetn_in) reg_rd_in && reg_addr_in[7:0] == eclk_pkg::OFS_CMP
    |=> reg_rdata_out == 32'h0)
    else $error("unlock readable");
  a_full_count: assert property (@(posedge clock_in) disable iff
    (!resetn_in) launch_go && !cmd_new[1] && reg_wdata_in[28:24] == 5'h00
    |=> fab_req_out.count == 6'h20)
    else $error("zero count not 32");
  a_locked_refuse: assert property (@(posedge clock_in) disable iff
    (!resetn_in) (wr_launch && lock_bit) |=> !fab_start_out)
    else $error("locked access started");


  // ==========================================================
  // Transfer progress checks
  a_done_finish: assert property (@(posedge clock_in) disable iff
    (!resetn_in)
    state == eclk_pkg::ECLK_ST_RUN && fab_done_in
    |=> done_flag && !busy)
    else $error("finish did not set done");
  a_busy_holds: assert property (@(posedge clock_in) disable iff
    (!resetn_in)
    state == eclk_pkg::ECLK_ST_RUN && !fab_done_in
    |=> busy)
    else $error("busy dropped early");
  a_start_cause: assert property (@(posedge clock_in) disable iff
    (!resetn_in)
    fab_start_out
    |-> $past(launch_go))
    else $error("start without launch");
  a_done_clear: assert property (@(posedge clock_in) disable iff
    (!resetn_in)
    wr_status && reg_wdata_in[0] && !(state == eclk_pkg::ECLK_ST_RUN &&
    fab_done_in) |=> !done_flag)
    else $error("done not cleared");
  a_err_clear: assert property (@(posedge clock_in) disable iff
    (!resetn_in)
    wr_status && reg_wdata_in[1]
    |=> !err_flag)
    else $error("error not cleared");
  a_err_keeps_req: assert property (@(posedge clock_in) disable iff
    (!resetn_in)
    launch_err
    |=> $stable(fab_req_out))
    else $error("refused launch changed request");

  // ==========================================================
  // Request field and done interrupt checks
  a_cmd_forward: assert property (@(posedge clock_in) disable iff
    (!resetn_in)
    launch_go
    |=> fab_req_out.cmd == $past(cmd_new))
    else $error("command not forwarded");
  a_addr_forward: assert property (@(posedge clock_in) disable iff
    (!resetn_in)
    launch_go && !cmd_new[1]
    |=> fab_req_out.addr == $past(reg_wdata_in[10:0]))
    else $error("address not forwarded");
  a_count_forward: assert property (@(posedge clock_in) disable iff
    (!resetn_in)
    launch_go && !cmd_new[1] && reg_wdata_in[28:24] != 5'h00
    |=> fab_req_out.count == {1'b0, $past(reg_wdata_in[28:24])})
    else $error("count not forwarded");
  a_status_count: assert property (@(posedge clock_in) disable iff
    (!resetn_in)
    launch_go && cmd_new[1]
    |=> fab_req_out.count == 6'h01)
    else $error("status count not one");
  a_status_addr: assert property (@(posedge clock_in) disable iff
    (!resetn_in)
    launch_go && cmd_new[1]
    |=> fab_req_out.addr == 11'h000)
    else $error("status address not zero");
  a_irq_done_on: assert property (@(posedge clock_in) disable iff
    (!resetn_in)
    mask[0] && done_flag
    |-> irq_out)
    else $error("done irq missing");

  // ==========================================================
  // Key and lock checks
  a_key_once: assert property (@(posedge clock_in) disable iff
    (!resetn_in)
    wr_key && key_written
    |=> key == $past(key))
    else $error("key rewritten");
  a_key_read_zero: assert property (@(posedge clock_in) disable iff
    (!resetn_in)
    reg_rd_in && reg_addr_in[7:0] == eclk_pkg::OFS_KEY
    |=> reg_rdata_out == 32'h0)
    else $error("key readable");
  a_unlock_match: assert property (@(posedge clock_in) disable iff
    (!resetn_in)
    wr_cmp && state != eclk_pkg::ECLK_ST_BOOT && reg_wdata_in[30:0] == key
    |=> !lock_bit)
    else $error("matching key left lock");
  a_lock_holds: assert property (@(posedge clock_in) disable iff
    (!resetn_in)
    lock_bit && !wr_cmp
    |=> lock_bit)
    else $error("lock cleared without compare");
  a_boot_lock: assert property (@(posedge clock_in) disable iff
    (!resetn_in)
    state == eclk_pkg::ECLK_ST_BOOT && boot_valid_in && boot_word_in[31]
    |=> lock_bit && key == $past(boot_word_in[30:0]))
    else $error("boot word did not lock");

  // ==========================================================
  // Scenario covers
  c_transfer_done: cover property (@(posedge clock_in) disable iff
    (!resetn_in) $rose(done_flag));
  c_status_cmd: cover property (@(posedge clock_in) disable iff
    (!resetn_in) launch_go && cmd_new[1]);
  c_bad_cmd: cover property (@(posedge clock_in) disable iff
    (!resetn_in) wr_launch && !cmd_legal);
  c_busy_error: cover property (@(posedge clock_in) disable iff
    (!resetn_in) wr_launch && busy);
  c_unlock: cover property (@(posedge clock_in) disable iff
    (!resetn_in) $fell(lock_bit));

endmodule : eclk_ctrl

//--- shared/eclk_pkg.sv
// Package: register map, field layout and constants of the EEPROM command/lock block
// Functional notes
// - Byte count from execute bits 28:24; zero means 32 bytes.
// - Byte count used only for array read and array write.
// - An execute write when idle, unlocked and with a defined code launches a transfer with command bits 18:16.
// - Command 0 array read, 1 array write, 2 status read, 3 status write.
// - Byte address used only for array read and write commands.
// - Busy flag at status bit 8 high while a transfer runs.
// - Execute write while busy sets error bit 1; write one clears it.
// - Undefined command code also sets error bit 1.
// - Done flag bit 0 set when transfer ends; write one clears.
// - Mask bit 1 lets the error flag drive the interrupt.
// - Mask bit 0 lets the done flag drive the interrupt.
// - Key accepted once into bits 30:0, then blocked until system reset.
// - Unlock write compares low 31 bits to key; match clears lock.
// - Unlock register is write-only and reads as zero.
// - While locked all array accesses refused; only reset or match unlocks.
// - At boot, word 7FCh with bit 31 set loads key and sets lock.
// - 32-byte buffer exchanges data; status commands use only byte 0.
package eclk_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_LAUNCH = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0c;
  localparam logic [7:0] OFS_KEY = 8'h10;
  localparam logic [7:0] OFS_CMP = 8'h14;
  localparam logic [7:0] OFS_LOCK = 8'h18;

  // ==========================================================
  // Field positions
  localparam int SIZE_LSB = 24;
  localparam int CMD_LSB = 16;
  localparam int BUSY_BIT = 8;
  localparam int ERR_BIT = 1;
  localparam int DONE_BIT = 0;
  localparam int LOCK_BIT = 1;
  localparam int KEY_VALID_BIT = 31;
  localparam logic [10:0] BOOT_KEY_ADDR = 11'h7fc;
  localparam logic [5:0] FULL_COUNT = 6'h20;

  // ==========================================================
  // Reset values
  localparam logic [31:0] LAUNCH_RST = 32'h0000_0000;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [30:0] KEY_RST = 31'h0000_0000;

  typedef enum logic [2:0] {
    ECLK_CMD_RD = 3'h0,
    ECLK_CMD_WR = 3'h1,
    ECLK_CMD_SRD = 3'h2,
    ECLK_CMD_SWR = 3'h3
  } eclk_cmd_t;

  typedef enum logic [1:0] {
    ECLK_ST_IDLE = 2'h0,
    ECLK_ST_RUN = 2'h1,
    ECLK_ST_BOOT = 2'h2
  } eclk_state_t;

  // Request to the array fabric
  typedef struct packed {
    logic [2:0] cmd;
    logic [10:0] addr;
    logic [5:0] count;
  } eclk_req_t;

endpackage : eclk_pkg

//--- tb/eclk_fabric_model.sv
// Array fabric model: answers each transfer start with a done pulse
`timescale 1ns/1ps
module eclk_fabric_model (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Transfer handshake
  input wire logic fab_start_in,
  input wire logic [7:0] lat_in,
  output logic fab_done_out
);
  logic [7:0] cnt;
  // ==========================================================
  // Transfer timing
  // Latency is set by the bench; a slow array is the normal case
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt <= 8'h00;
    end else if (fab_start_in) begin
      cnt <= lat_in;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end
  assign fab_done_out = (cnt == 8'h01);
endmodule : eclk_fabric_model

//--- tb/eeprom_command_lock_ctrl_tb.sv
// Testbench: register-level checks of the EEPROM command and lock block
`timescale 1ns/1ps
module eeprom_command_lock_ctrl_tb;
  localparam logic [7:0] LA = eclk_pkg::OFS_LAUNCH;
  localparam logic [7:0] ST = eclk_pkg::OFS_STATUS;
  localparam logic [7:0] MK = eclk_pkg::OFS_MASK;
  localparam logic [7:0] LK = eclk_pkg::OFS_LOCK;
  localparam logic [7:0] CP = eclk_pkg::OFS_CMP;
  localparam logic [30:0] KEY = 31'h1234_5678;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic fab_start_out;
  logic fab_done_in;
  logic irq_out;
  logic boot_valid_in = 1'b0;
  logic [31:0] boot_word_in = 32'h0;
  eclk_pkg::eclk_req_t fab_req_out;
  logic [7:0] lat = 8'h04;
  logic [1:0] mask = 2'h0;
  logic [31:0] rv;
  eclk_pkg::eclk_req_t exp_q[$];
  int n_errors = 0;
  int comparisons = 0;
  int c;
  always #25 clock_in = ~clock_in;
  eclk_ctrl dut (.clock_in(clock_in), .resetn_in(resetn_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .fab_start_out(fab_start_out),
    .fab_req_out(fab_req_out), .fab_done_in(fab_done_in),
    .boot_word_in(boot_word_in), .boot_valid_in(boot_valid_in),
    .irq_out(irq_out));
  eclk_fabric_model fab (.clock_in(clock_in), .resetn_in(resetn_in),
    .fab_start_in(fab_start_out), .lat_in(lat), .fab_done_out(fab_done_in));
  // ==========================================================
  // Bus tasks and comparison
  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Model: every start must match the oldest expected request
  always @(posedge clock_in) begin
    if (resetn_in && fab_start_out) begin
      if (exp_q.size() == 0) begin
        chk("unexpected start", 1, 0);
      end else begin
        chk("model req", fab_req_out, exp_q.pop_front());
      end
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1 rv = reg_rdata_out;
  endtask : rd
  // Done pulse is sampled by the block one edge after it shows
  task automatic wait_done();
    int i;
    for (i = 0; i < 300 && fab_done_in !== 1'b1; i++) begin
      @(posedge clock_in);
      #1;
    end
    chk("fabric done", fab_done_in, 1);
    @(posedge clock_in);
    #1;
  endtask : wait_done
  task automatic do_reset(input logic [31:0] bw);
    @(posedge clock_in);
    resetn_in <= 1'b0;
    boot_word_in <= bw;
    repeat (12) @(posedge clock_in);
    resetn_in <= 1'b1;
    rd(ST);
    chk("boot busy", rv, 32'h100);
    @(posedge clock_in);
    boot_valid_in <= 1'b1;
    @(posedge clock_in);
    boot_valid_in <= 1'b0;
  endtask : do_reset
  task automatic launch(input int cmd, sz, ad);
    int en;
    en = cmd >= 2 ? 1 : (sz == 0 ? 32 : sz);
    exp_q.push_back({3'(cmd), 11'(cmd < 2 ? ad : 0), 6'(en)});
    wr(LA, {3'h0, 5'(sz), 5'h0, 3'(cmd), 16'(ad)});
    chk("start", fab_start_out, 1);
    chk("req cmd", fab_req_out.cmd, cmd);
    chk("req addr", fab_req_out.addr, cmd < 2 ? ad : 0);
    chk("req count", fab_req_out.count, en);
    rd(ST);
    chk("busy", rv, 32'h100);
    wait_done();
    rd(ST);
    chk("done", rv, 32'h1);
    chk("done irq", irq_out, mask[0]);
    wr(ST, 32'h1);
    chk("irq off", irq_out, 0);
  endtask : launch
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(63821));
    do_reset(32'h0);
    rd(LK);
    chk("no lock", rv, 0);
    mask = 2'h1;
    wr(MK, {30'h0, mask});
    rd(MK);
    chk("mask", rv, 32'h1);
    for (c = 0; c < 4; c++) begin
      lat = 8'(4 + $urandom % 9);
      launch(c, c == 0 ? 0 : $urandom % 32, $urandom % 2048);
    end
    lat = 8'h14;
    mask = 2'h2;
    wr(MK, 32'h2);
    exp_q.push_back({3'h0, 11'h123, 6'h20});
    wr(LA, 32'h0000_0123);
    wr(LA, 32'h0201_0456);
    chk("kept req", fab_req_out.addr, 11'h123);
    rd(ST);
    chk("busy err", rv, 32'h102);
    chk("err irq", irq_out, 1);
    wr(ST, 32'h2);
    chk("err clear", irq_out, 0);
    wait_done();
    rd(ST);
    chk("one done", rv, 32'h1);
    chk("no done irq", irq_out, 0);
    wr(ST, 32'h1);
    for (c = 4; c < 8; c++) begin
      wr(LA, {13'h0, 3'(c), 16'h0});
      chk("bad start", fab_start_out, 0);
      rd(ST);
      chk("bad cmd", rv, 32'h2);
      wr(ST, 32'h2);
    end
    rd(CP);
    chk("unlock read", rv, 0);
    rd(eclk_pkg::OFS_KEY);
    chk("key read", rv, 0);
    do_reset({1'b1, KEY});
    rd(LK);
    chk("boot lock", rv, 32'h2);
    wr(LA, 32'h0);
    chk("locked start", fab_start_out, 0);
    rd(ST);
    chk("locked err", rv, 32'h2);
    wr(ST, 32'h2);
    wr(CP, {1'b0, KEY ^ 31'h1});
    rd(LK);
    chk("wrong key", rv, 32'h2);
    wr(CP, {1'b1, KEY});
    rd(LK);
    chk("unlocked", rv, 0);
    mask = 2'h0;
    wr(MK, 32'h0);
    lat = 8'h05;
    launch(1, 5, 16'h7e0);
    chk("queue left", exp_q.size(), 0);
    end_of_test();
  end
  initial begin
    #(5000 * 50);
    n_errors++;
    end_of_test();
  end
endmodule : eeprom_command_lock_ctrl_tb
